// ===== rtl/mac_collision_filter_pad_ctrl.sv
// mac control bits: collision retry, broadcast filter, pad strip, wake
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps

module mac_collision_filter_pad_ctrl import mac_cfg_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdata,
  // transmitter events and decisions
  input wire logic txFrameStart,
  input wire logic txCollision,
  input wire logic txLateCollision,
  input wire logic txSent,
  output logic txRetry,
  output logic txDrop,
  output tx_stat_s txStatus,
  output logic txStatusValid,
  // receive stream
  input wire rx_beat_s rxIn,
  output rx_beat_s rxOut,
  // wake detection
  input wire logic wakeFrameMatch,
  output logic wakeEvent,
  // interrupt
  output logic irq
);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // control state
  logic lateRetryEn;
  logic broadcastRxDisable;
  logic retryDisable;
  logic autoPadStripEn;
  logic wakeFrameDetectEn;
  logic [IRQ_W-1:0] irqStat;
  logic [IRQ_W-1:0] irqEn;
  tx_stat_s lastTxStat;
  logic txBusy;

  // receive side state
  rx_beat_s hold [HOLD_DEPTH];
  logic [2:0] occ;
  logic [2:0] eofCnt;
  logic [6:0] inIdx;
  logic allOnes;
  logic [15:0] lenReg;
  logic [6:0] outIdx;
  logic dropLatched;
  logic stripLatched;
  logic bcastDropped;
  logic padStripped;

  // receive combinational terms
  logic push;
  logic pop;
  logic [2:0] wrIdx;
  logic isBcast;
  rx_beat_s head;
  logic [6:0] curIdx;
  logic frameDrop;
  logic stripOn;
  logic [6:0] keepLen;
  logic beyond;
  logic lastKept;
  logic [6:0] pushIdx;

  logic [IRQ_W-1:0] irqEvents;
  logic [IRQ_W-1:0] irqClr;

  function automatic logic [6:0] satInc(input logic [6:0] v);
    satInc = (v == IDX_MAX) ? v : v + 7'h01;
  endfunction

  // ---------------- register port ----------------

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lateRetryEn <= 1'b0;
      broadcastRxDisable <= 1'b0;
      retryDisable <= 1'b0;
      autoPadStripEn <= 1'b0;
    end else if (regWrite && regAddr == CTRL_OFS) begin
      lateRetryEn <= regWdata[LCOL_BIT];
      broadcastRxDisable <= regWdata[BROADCAST_RX_DISABLE_BIT];
      retryDisable <= regWdata[RETRY_BIT];
      autoPadStripEn <= regWdata[PAD_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wakeFrameDetectEn <= 1'b0;
    end else if (regWrite && regAddr == WAKE_OFS) begin
      wakeFrameDetectEn <= regWdata[WAKE_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irqEn <= '0;
    end else if (regWrite && regAddr == IRQ_EN_OFS) begin
      irqEn <= regWdata[IRQ_W-1:0];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else if (regRead) begin
      regRdata <= '0;
      if (regAddr == CTRL_OFS) begin
        regRdata[LCOL_BIT] <= lateRetryEn;
        regRdata[BROADCAST_RX_DISABLE_BIT] <= broadcastRxDisable;
        regRdata[RETRY_BIT] <= retryDisable;
        regRdata[PAD_BIT] <= autoPadStripEn;
      end else if (regAddr == WAKE_OFS) begin
        regRdata[WAKE_EN_BIT] <= wakeFrameDetectEn;
      end else if (regAddr == IRQ_STAT_OFS) begin
        regRdata[IRQ_W-1:0] <= irqStat;
      end else if (regAddr == IRQ_EN_OFS) begin
        regRdata[IRQ_W-1:0] <= irqEn;
      end else if (regAddr == TX_STAT_OFS) begin
        regRdata[$bits(tx_stat_s)-1:0] <= lastTxStat;
      end
    end else begin
      regRdata <= '0;
    end
  end

  // ---------------- transmit ----------------

  tx_attempt_ctrl txCtrl (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .lateRetryEn(lateRetryEn),
    .retryDisable(retryDisable),
    .txFrameStart(txFrameStart),
    .txCollision(txCollision),
    .txLateCollision(txLateCollision),
    .txSent(txSent),
    .txRetry(txRetry),
    .txDrop(txDrop),
    .txStatus(txStatus),
    .txStatusValid(txStatusValid),
    .busy(txBusy)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lastTxStat <= '0;
    end else if (txStatusValid) begin
      lastTxStat <= txStatus;
    end
  end

  // ---------------- receive ----------------
  // six bytes are held back so the broadcast verdict is known
  // before the first byte leaves; an eof in the hold lets it drain

  always_comb begin
    push = rxIn.valid;
    pop = push ? (occ == 3'(HOLD_DEPTH)) : (occ != '0 && eofCnt != '0);
    wrIdx = occ - {2'b00, pop};
    head = hold[0];
    pushIdx = rxIn.sof ? '0 : inIdx;
    isBcast = allOnes && inIdx >= DEST_BYTES;
    curIdx = head.sof ? '0 : outIdx;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < HOLD_DEPTH; i++) begin
        hold[i] <= '0;
      end
      occ <= '0;
    end else begin
      if (pop) begin
        for (int i = 0; i < HOLD_DEPTH - 1; i++) begin
          hold[i] <= hold[i+1];
        end
      end
      if (push) begin
        hold[wrIdx] <= rxIn;
      end
      occ <= occ + {2'b00, push} - {2'b00, pop};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      eofCnt <= '0;
    end else begin
      eofCnt <= eofCnt + {2'b00, push && rxIn.eof}
        - {2'b00, pop && head.eof};
    end
  end

  // arrival side: destination and length field capture
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      inIdx <= '0;
      allOnes <= 1'b0;
      lenReg <= '0;
    end else if (push) begin
      inIdx <= satInc(pushIdx);
      if (rxIn.sof) begin
        allOnes <= rxIn.data == BROADCAST_RX_DISABLE_BYTE;
      end else if (pushIdx < DEST_BYTES) begin
        allOnes <= allOnes && rxIn.data == BROADCAST_RX_DISABLE_BYTE;
      end
      if (pushIdx == LEN_HI_IDX) begin
        lenReg[15:8] <= rxIn.data;
      end
      if (pushIdx == LEN_LO_IDX) begin
        lenReg[7:0] <= rxIn.data;
      end
    end
  end

  // departure side verdicts, latched at each frame's first byte
  always_comb begin
    frameDrop = head.sof ? (broadcastRxDisable && isBcast) : dropLatched;
    stripOn = (head.sof ? autoPadStripEn : stripLatched)
      && lenReg < MIN_PAYLOAD;
    keepLen = HDR_BYTES + lenReg[6:0];
    beyond = stripOn && curIdx >= keepLen;
    lastKept = stripOn && curIdx == keepLen - 7'h01;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      outIdx <= '0;
      dropLatched <= 1'b0;
      stripLatched <= 1'b0;
    end else if (pop) begin
      outIdx <= satInc(curIdx);
      if (head.sof) begin
        dropLatched <= broadcastRxDisable && isBcast;
        stripLatched <= autoPadStripEn;
      end
    end
  end

  // tail past the kept length is dropped, eof moves onto last kept byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxOut <= '0;
      bcastDropped <= 1'b0;
      padStripped <= 1'b0;
    end else begin
      rxOut.valid <= pop && !frameDrop && !beyond;
      rxOut.sof <= head.sof;
      rxOut.eof <= head.eof || lastKept;
      rxOut.data <= head.data;
      bcastDropped <= pop && head.sof && frameDrop;
      padStripped <= pop && !frameDrop && lastKept && !head.eof;
    end
  end

  // ---------------- wake ----------------
  // wake path ignores the broadcast filter on purpose
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wakeEvent <= 1'b0;
    end else begin
      wakeEvent <= wakeFrameDetectEn && wakeFrameMatch;
    end
  end

  // ---------------- interrupts ----------------

  always_comb begin
    irqEvents = '0;
    irqEvents[IRQ_TX_LATE] = txBusy && txCollision && txLateCollision;
    irqEvents[IRQ_TX_RETRY_ERR] = txStatusValid && txStatus.retryErr;
    irqEvents[IRQ_RX_BROADCAST_RX_DISABLE_DROP] = bcastDropped;
    irqEvents[IRQ_RX_PAD_STRIP] = padStripped;
    irqEvents[IRQ_WAKE] = wakeEvent;
    irqClr = (regWrite && regAddr == IRQ_CLR_OFS) ? regWdata[IRQ_W-1:0] : '0;
  end

  // a set in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irqStat <= '0;
      irq <= 1'b0;
    end else begin
      irqStat <= (irqStat & ~irqClr) | irqEvents;
      irq <= |(((irqStat & ~irqClr) | irqEvents) & irqEn);
    end
  end

  // ---------------- checks ----------------

  a_late_retry_on: assert property (
    txBusy && txCollision && txLateCollision && lateRetryEn
      && !retryDisable && txCtrl.attempts < MAX_ATTEMPTS
      |=> txRetry && !txDrop)
    else $error("late collision not retried");

  a_late_abandon: assert property (
    txBusy && txCollision && txLateCollision && !lateRetryEn
      |=> txDrop && !txRetry ##1 !txBusy)
    else $error("late collision frame not abandoned");

  a_late_status: assert property (
    txBusy && txCollision && txLateCollision && !lateRetryEn
      |=> txStatusValid && txStatus.lateColl ##1 lastTxStat.lateColl)
    else $error("late collision missing from status");

  a_broadcast_rx_disable_drop: assert property (
    pop && head.sof && broadcastRxDisable && isBcast
      |=> !rxOut.valid && bcastDropped)
    else $error("broadcast frame delivered while disabled");

  a_wake_broadcast_rx_disable: assert property (
    wakeFrameMatch && wakeFrameDetectEn |=> wakeEvent)
    else $error("wake frame lost");

  a_single_try: assert property (
    txBusy && txCollision && retryDisable
      |=> txDrop && txStatus.retryErr && txStatus.attempts == FIRST_ATTEMPT)
    else $error("retry disable did not drop after one try");

  a_retry_limit: assert property (
    txStatusValid && txStatus.retryErr && !$past(retryDisable)
      |-> txStatus.attempts == MAX_ATTEMPTS)
    else $error("retry error before sixteen attempts");

  a_strip_tail: assert property (
    pop && beyond |=> !rxOut.valid)
    else $error("pad or fcs byte delivered");

  a_long_pass: assert property (
    pop && !frameDrop && lenReg >= MIN_PAYLOAD
      |=> rxOut.valid && rxOut.eof == $past(head.eof))
    else $error("long frame modified");

  a_no_strip: assert property (
    pop && !frameDrop && !stripOn
      |=> rxOut.valid && rxOut.data == $past(head.data))
    else $error("frame modified with strip off");

  a_ctrl_reset: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    !rst_n |=> !lateRetryEn && !broadcastRxDisable
      && !retryDisable && !autoPadStripEn)
    else $error("control bits not cleared by reset");

  c_late_retry: cover property (txRetry && $past(txLateCollision));
  c_retry_limit: cover property (txDrop && txStatus.retryErr);
  c_broadcast_rx_disable_drop: cover property (bcastDropped);
  c_pad_strip: cover property (padStripped);

endmodule // mac_collision_filter_pad_ctrl

// ===== rtl/mac_cfg_pkg.sv
// constants, layouts and types shared by the collision, filter and pad logic
package mac_cfg_pkg;

  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WAKE_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h0C;
  localparam logic [7:0] IRQ_EN_OFS = 8'h10;
  localparam logic [7:0] TX_STAT_OFS = 8'h14;

  // control register fields
  localparam int LCOL_BIT = 12;
  localparam int BROADCAST_RX_DISABLE_BIT = 11;
  localparam int RETRY_BIT = 10;
  localparam int PAD_BIT = 8;

  // wake register field
  localparam int WAKE_EN_BIT = 2;

  // interrupt status layout
  localparam int IRQ_W = 5;
  localparam int IRQ_TX_LATE = 0;
  localparam int IRQ_TX_RETRY_ERR = 1;
  localparam int IRQ_RX_BROADCAST_RX_DISABLE_DROP = 2;
  localparam int IRQ_RX_PAD_STRIP = 3;
  localparam int IRQ_WAKE = 4;

  // transmit attempt limit
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [4:0] FIRST_ATTEMPT = 5'h01;

  // receive frame geometry, in byte indexes
  localparam int HOLD_DEPTH = 6;
  localparam logic [6:0] DEST_BYTES = 7'h06;
  localparam logic [6:0] LEN_HI_IDX = 7'h0C;
  localparam logic [6:0] LEN_LO_IDX = 7'h0D;
  localparam logic [6:0] HDR_BYTES = 7'h0E;
  localparam logic [6:0] IDX_MAX = 7'h7F;
  localparam logic [15:0] MIN_PAYLOAD = 16'h002E;
  localparam logic [7:0] BROADCAST_RX_DISABLE_BYTE = 8'hFF;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } rx_beat_s;

  typedef struct packed {
    logic lateColl;
    logic retryErr;
    logic [4:0] attempts;
  } tx_stat_s;

  typedef enum logic {TX_IDLE, TX_BUSY} tx_state_e;

endpackage

// ===== rtl/tx_attempt_ctrl.sv
// transmit attempt sequencing: retry, drop and per-frame status
`timescale 1ns/100ps
module tx_attempt_ctrl import mac_cfg_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control bits
  input wire logic lateRetryEn,
  input wire logic retryDisable,
  // transmitter events
  input wire logic txFrameStart,
  input wire logic txCollision,
  input wire logic txLateCollision,
  input wire logic txSent,
  // decisions and status
  output logic txRetry,
  output logic txDrop,
  output tx_stat_s txStatus,
  output logic txStatusValid,
  output logic busy
);

  tx_state_e state;
  logic [4:0] attempts;
  logic lateSeen;
  logic giveUp;
  logic retryErr;

  // late collision with retry off abandons at once
  always_comb begin
    retryErr = retryDisable || attempts == MAX_ATTEMPTS;
    giveUp = (txLateCollision && !lateRetryEn) || retryErr;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= TX_IDLE;
      attempts <= '0;
      lateSeen <= 1'b0;
      txRetry <= 1'b0;
      txDrop <= 1'b0;
      txStatus <= '0;
      txStatusValid <= 1'b0;
    end else begin
      txRetry <= 1'b0;
      txDrop <= 1'b0;
      txStatusValid <= 1'b0;
      case (state)
        TX_IDLE: begin
          if (txFrameStart) begin
            state <= TX_BUSY;
            attempts <= FIRST_ATTEMPT;
            lateSeen <= 1'b0;
          end
        end
        TX_BUSY: begin
          if (txCollision) begin
            if (giveUp) begin
              state <= TX_IDLE;
              txDrop <= 1'b1;
              txStatusValid <= 1'b1;
              txStatus.lateColl <= lateSeen || txLateCollision;
              txStatus.retryErr <= retryErr;
              txStatus.attempts <= attempts;
            end else begin
              txRetry <= 1'b1;
              attempts <= attempts + FIRST_ATTEMPT;
              lateSeen <= lateSeen || txLateCollision;
            end
          end else if (txSent) begin
            state <= TX_IDLE;
            txStatusValid <= 1'b1;
            txStatus.lateColl <= lateSeen;
            txStatus.retryErr <= 1'b0;
            txStatus.attempts <= attempts;
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  assign busy = state == TX_BUSY;

endmodule // tx_attempt_ctrl

// ===== verif/phy_model.sv
// far-side model: transmitter event source and receive byte stream
`timescale 1ns/100ps
module phy_model import mac_cfg_pkg::*; (
  // clock
  input wire logic sys_clk,
  // receive stream toward the block
  output rx_beat_s rxIn,
  // transmitter events
  output logic txFrameStart,
  output logic txCollision,
  output logic txLateCollision,
  output logic txSent
);
  initial begin
    rxIn = '0;
    {txFrameStart, txCollision, txLateCollision, txSent} = 4'h0;
  end

  // one-cycle event pulse: {start, collision, late, sent}
  task automatic ev(input logic [3:0] v);
    @(posedge sys_clk);
    {txFrameStart, txCollision, txLateCollision, txSent} <= v;
    @(posedge sys_clk);
    {txFrameStart, txCollision, txLateCollision, txSent} <= 4'h0;
  endtask

  // frame: dest byte x6, source, length field, counting payload
  task automatic sendFrame(input logic [7:0] d, input logic [15:0] len,
                           input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rxIn.valid <= 1'b1;
      rxIn.sof <= (i == 0);
      rxIn.eof <= (i == n - 1);
      rxIn.data <= (i < 6) ? d : (i < 12) ? 8'h11 :
                   (i == 12) ? len[15:8] : (i == 13) ? len[7:0] : 8'(i);
    end
    @(posedge sys_clk);
    // idle line must not look like the last byte
    rxIn <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~rxIn.data};
  endtask
endmodule // phy_model

// ===== verif/tb_top.sv
// self-checking bench for the collision, filter and pad control block
`timescale 1ns/100ps
module tb_top import mac_cfg_pkg::*;;
  logic sys_clk;
  logic rst_n;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic regWrite;
  logic regRead;
  logic wakeFrameMatch;
  logic [DATA_W-1:0] regRdata;
  logic txFrameStart, txCollision, txLateCollision, txSent;
  logic txRetry, txDrop, txStatusValid, wakeEvent, irq;
  tx_stat_s txStatus;
  rx_beat_s rxIn, rxOut;
  int miscompares = 0;
  int numChecks = 0;
  int cyc = 0;
  int rxCnt = 0;
  int eofAt = -1;
  int rxBad = 0;
  logic [7:0] expDst = '0;
  logic [15:0] expLen = '0;

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  phy_model phy_model_i (.sys_clk(sys_clk), .rxIn(rxIn),
    .txFrameStart(txFrameStart), .txCollision(txCollision),
    .txLateCollision(txLateCollision), .txSent(txSent));

  mac_collision_filter_pad_ctrl mac_collision_filter_pad_ctrl_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .txFrameStart(txFrameStart),
    .txCollision(txCollision), .txLateCollision(txLateCollision),
    .txSent(txSent), .txRetry(txRetry), .txDrop(txDrop),
    .txStatus(txStatus), .txStatusValid(txStatusValid), .rxIn(rxIn),
    .rxOut(rxOut), .wakeFrameMatch(wakeFrameMatch),
    .wakeEvent(wakeEvent), .irq(irq));

  // delivered byte count and position of the end marker
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rxOut.valid === 1'b1) begin
      rxCnt <= rxCnt + 1;
      if (rxOut.eof === 1'b1) eofAt <= rxCnt + 1;
      // every delivered byte must match its place in the sent frame
      if (rxOut.data !== expByte(rxCnt) || rxOut.sof !== (rxCnt == 0)) begin
        rxBad <= rxBad + 1;
      end
    end
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (miscompares == 0 && numChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    numChecks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // byte pattern of the partner's frames, by position
  function automatic logic [7:0] expByte(input int i);
    if (i < 6) return expDst;
    if (i < 12) return 8'h11;
    if (i == 12) return expLen[15:8];
    if (i == 13) return expLen[7:0];
    return 8'(i);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic t_regs();
    logic [31:0] d;
    rd(CTRL_OFS, d);
    chk("ctrl reset", 32'h0000_0000, d);
    wr(CTRL_OFS, 32'hFFFF_FFFF);
    rd(CTRL_OFS, d);
    chk("ctrl rw", 32'h0000_1D00, d);
    wr(8'hF0, 32'hFFFF_FFFF);
    rd(8'hF0, d);
    chk("unmapped", 32'h0000_0000, d);
  endtask

  task automatic t_noretry();
    logic [31:0] d;
    wr(CTRL_OFS, 32'h0000_0400);
    phy_model_i.ev(4'h8);
    phy_model_i.ev(4'h4);
    #1 chk("drop", 32'h3, {txDrop, txStatusValid});
    chk("status", {1'b0, 1'b1, 5'h01}, txStatus);
    rd(TX_STAT_OFS, d);
    chk("tx stat reg", {1'b0, 1'b1, 5'h01}, d);
  endtask

  task automatic t_sixteen();
    wr(CTRL_OFS, 32'h0000_0000);
    phy_model_i.ev(4'h8);
    for (int i = 1; i < 16; i++) begin
      phy_model_i.ev(4'h4);
      #1 chk("retry", 32'h2, {txRetry, txDrop});
    end
    phy_model_i.ev(4'h4);
    #1 chk("drop16", 32'h1, {txRetry, txDrop});
    chk("status16", {1'b0, 1'b1, 5'h10}, txStatus);
  endtask

  task automatic t_late(input logic en);
    logic [31:0] d;
    wr(IRQ_EN_OFS, 32'h0000_0001);
    wr(CTRL_OFS, {19'h0, en, 12'h0});
    phy_model_i.ev(4'h8);
    phy_model_i.ev(4'h6);
    #1 chk("late act", {30'h0, en, ~en}, {txRetry, txDrop});
    if (en) begin
      phy_model_i.ev(4'h1);
      #1 chk("late sent", {1'b1, 1'b0, 5'h02}, txStatus);
    end else begin
      chk("late stat", {1'b1, 1'b0, 5'h01}, txStatus);
    end
    chk("irq set", 32'h1, irq);
    wr(IRQ_CLR_OFS, 32'h0000_001F);
    rd(IRQ_STAT_OFS, d);
    chk("irq clr", 32'h0, {d[IRQ_TX_LATE], irq});
  endtask

  task automatic t_rx(input logic [31:0] ctl, input logic [7:0] dst,
                      input logic [15:0] len, input int expN);
    logic [31:0] d;
    logic [1:0] e;
    wr(CTRL_OFS, ctl);
    wr(IRQ_CLR_OFS, 32'h0000_001F);
    rxCnt = 0;
    rxBad = 0;
    eofAt = -1;
    expDst = dst;
    expLen = len;
    phy_model_i.sendFrame(dst, len, 64);
    repeat (14) @(posedge sys_clk);
    chk("rx bytes", expN, rxCnt);
    chk("rx eof", (expN == 0) ? -1 : expN, eofAt);
    chk("rx data", 32'h0, rxBad);
    // pad-strip flag above the broadcast-drop flag
    e = {ctl[PAD_BIT] && len < MIN_PAYLOAD,
         ctl[BROADCAST_RX_DISABLE_BIT] && dst == BROADCAST_RX_DISABLE_BYTE};
    rd(IRQ_STAT_OFS, d);
    chk("rx irq", e, d[IRQ_RX_PAD_STRIP:IRQ_RX_BROADCAST_RX_DISABLE_DROP]);
  endtask

  task automatic t_wake();
    logic [31:0] d;
    wr(WAKE_OFS, 32'h0000_0004);
    wr(CTRL_OFS, 32'h0000_0800);
    @(posedge sys_clk);
    wakeFrameMatch <= 1'b1;
    @(posedge sys_clk);
    wakeFrameMatch <= 1'b0;
    #1 chk("wake", 32'h1, wakeEvent);
    rd(IRQ_STAT_OFS, d);
    chk("wake irq", 32'h1, d[IRQ_WAKE]);
  endtask

  initial begin
    rst_n <= 1'b0;
    regAddr <= '0;
    regWdata <= '0;
    regWrite <= 1'b0;
    regRead <= 1'b0;
    wakeFrameMatch <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_noretry();
    t_sixteen();
    t_late(1'b0);
    t_late(1'b1);
    t_late(1'b1);
    t_rx(32'h0000_0100, 8'h02, 16'h0002, 16);
    t_rx(32'h0000_0100, 8'h02, 16'h002E, 64);
    t_rx(32'h0000_0000, 8'h02, 16'h0002, 64);
    t_rx(32'h0000_0800, 8'hFF, 16'h002E, 0);
    t_rx(32'h0000_0000, 8'hFF, 16'h002E, 64);
    t_wake();
    end_of_test();
  end
endmodule // tb_top
